// [tcsp_pkg.sv]
// Constants and types shared by both ends of the touch controller I2C port.
// Assumes one 20 MHz system clock on each end.
package tcsp_pkg;
  // ---------------------------------------------------------------
  // Bus framing
  // ---------------------------------------------------------------
  localparam logic [6:0] TCSP_ADDR = 7'h4D;
  localparam logic [7:0] TCSP_ADDR_WR = 8'h9A;
  localparam logic [7:0] TCSP_ADDR_RD = 8'h9B;
  localparam logic [7:0] TCSP_REG_CMD = 8'h00;
  localparam logic [7:0] TCSP_HDR = 8'h55;
  localparam logic [7:0] TCSP_CMD_TOUCH_EN = 8'h12;
  localparam logic [7:0] TCSP_FILLER = 8'hFF;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int TCSP_CLK_HZ = 20_000_000;
  localparam int TCSP_SCL_MAX_HZ = 400_000;
  localparam int TCSP_QTR_CYC = (TCSP_CLK_HZ + 4 * TCSP_SCL_MAX_HZ - 1) / (4 * TCSP_SCL_MAX_HZ);
  localparam int TCSP_STOP_WAIT_US = 50;
  localparam int TCSP_STOP_WAIT_CYC = TCSP_STOP_WAIT_US * (TCSP_CLK_HZ / 1_000_000);
  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int TCSP_FIFO_DEPTH = 8;
  localparam int TCSP_BYTE_W = 8;
  localparam logic [2:0] TCSP_DEV_SYNC_RST = 3'h7;
  localparam logic [2:0] TCSP_HOST_SYNC_RST = 3'h3;
  localparam logic [3:0] TCSP_BIT_LAST = 4'h8;
  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {DS_IDLE, DS_ADDR, DS_ACK, DS_WR, DS_RD, DS_MACK, DS_SKIP} tcsp_dev_state_type;
  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_LOW, HS_HIGH, HS_WAIT, HS_STOP} tcsp_host_state_type;
endpackage

// [tcsp_if.sv]
// Open-drain SCL/SDA and the push-pull data-ready line between both ends.
// A line is low when any end enables its driver with a low output.
`timescale 1ns/100ps
interface tcsp_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic data_ready;
  wire scl;
  wire sda;
  assign scl = !((dev_scl_oe && !dev_scl_o) || (host_scl_oe && !host_scl_o));
  assign sda = !((dev_sda_oe && !dev_sda_o) || (host_sda_oe && !host_sda_o));
  modport device (input scl, input sda, output dev_scl_o, output dev_scl_oe,
                  output dev_sda_o, output dev_sda_oe, output data_ready);
  modport host (input scl, input sda, input data_ready, output host_scl_o,
                output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// [tcsp_device.sv]
// Device end of the touch controller I2C port, plus its report FIFO.
// Assumes bus pins and the strap come from outside the clock domain.
//
// How it works
// - Slave only, address 0x4D, up to 400 kHz.
// - Strap low selects the I2C port.
// - Only pulls SCL and SDA low.
// - Samples address and write bits on SCL rise.
// - Read data changes on SCL fall.
// - Data-ready rises when a report's first byte is queued, falls when that byte is read.
// - Address byte ends with direction bit.
// - Matching address acknowledged on ninth clock.
// - Bytes travel MSB first.
// - Every written data byte is acknowledged.
// - Master acks reads, nacks last, then stops.
// - Device may hold SCL low until ready.
// - Start is SDA falling with SCL high.
// - Stop is SDA rising with SCL high.
// - Master waits 50 us before stop after writes.
// - Command frame: 0x00, 0x55, size, bytes.
// - Sleep discards pending data and data-ready.
`timescale 1ns/100ps

module tcsp_fifo
  import tcsp_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = TCSP_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  // Depth must be a power of two so the pointers wrap by themselves.
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push_w;
  logic pop_w;

  assign push_w = in_valid_i && in_ready_o && !flush_i;
  assign pop_w = out_ready_i && out_valid_o && !flush_i;
  assign cnt_d = flush_i ? '0 : cnt_q + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge clk_sys_i) begin
    if (push_w) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wr_q <= flush_i ? '0 : wr_q + AW'(push_w);
      rd_q <= flush_i ? '0 : rd_q + AW'(pop_w);
      cnt_q <= cnt_d;
      in_ready_o <= cnt_d != FULL;
      out_valid_o <= cnt_d != '0;
    end
  end
endmodule // tcsp_fifo

module tcsp_device
  import tcsp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  tcsp_if.device bus,
  input wire logic host_if_select_strap_i,
  input wire logic sleep_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_first_i,
  output logic tx_ready_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_data_o,
  output logic cmd_last_o,
  input wire logic cmd_ready_i,
  output logic frame_err_o
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] filt_q;
  logic [2:0] prev_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= TCSP_DEV_SYNC_RST;
      s2_q <= TCSP_DEV_SYNC_RST;
      s3_q <= TCSP_DEV_SYNC_RST;
      filt_q <= TCSP_DEV_SYNC_RST;
      prev_q <= TCSP_DEV_SYNC_RST;
    end else begin
      s1_q <= {host_if_select_strap_i, bus.sda, bus.scl};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once two stages agree, which drops one-cycle glitches.
      filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
      prev_q <= filt_q;
    end
  end

  // ---------------------------------------------------------------
  // Bus events
  // ---------------------------------------------------------------
  logic en_w;
  logic rise_w;
  logic fall_w;
  logic start_w;
  logic stop_w;
  assign en_w = !filt_q[2];
  assign rise_w = filt_q[0] && !prev_q[0];
  assign fall_w = !filt_q[0] && prev_q[0];
  assign start_w = filt_q[0] && prev_q[0] && prev_q[1] && !filt_q[1];
  assign stop_w = filt_q[0] && prev_q[0] && !prev_q[1] && filt_q[1];

  // ---------------------------------------------------------------
  // Report FIFO
  // ---------------------------------------------------------------
  tcsp_dev_state_type st_q;
  logic rw_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic sda_oe_q;
  logic scl_oe_q;
  logic ready_q;
  logic [1:0] idx_q;
  logic [7:0] remain_q;
  logic fifo_valid_w;
  logic [8:0] fifo_data_w;
  logic pop_w;
  logic wr_done_w;
  logic [7:0] tx_byte_w;
  logic addr_hit_w;
  logic hdr_bad_w;

  assign pop_w = en_w && !stop_w && !start_w && fall_w &&
                 ((st_q == DS_ACK && rw_q) || st_q == DS_MACK);
  assign tx_byte_w = fifo_valid_w ? fifo_data_w[7:0] : TCSP_FILLER;
  assign wr_done_w = en_w && !stop_w && !start_w && fall_w && st_q == DS_WR && cnt_q == TCSP_BIT_LAST;
  assign addr_hit_w = sh_q[7:1] == TCSP_ADDR;
  assign hdr_bad_w = (idx_q == 2'h0 && sh_q != TCSP_REG_CMD) || (idx_q == 2'h1 && sh_q != TCSP_HDR);

  tcsp_fifo #(.WIDTH(9), .DEPTH(TCSP_FIFO_DEPTH)) tcsp_fifo_inst (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .flush_i(sleep_i),
    .in_valid_i(tx_valid_i),
    .in_data_i({tx_first_i, tx_data_i}),
    .in_ready_o(tx_ready_o),
    .out_valid_o(fifo_valid_w),
    .out_data_o(fifo_data_w),
    .out_ready_i(pop_w)
  );

  // ---------------------------------------------------------------
  // Data-ready flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_q <= 1'b0;
    end else if (sleep_i) begin
      ready_q <= 1'b0;
    end else if (tx_valid_i && tx_ready_o && tx_first_i) begin
      ready_q <= 1'b1;
    end else if (pop_w && fifo_valid_w && fifo_data_w[8]) begin
      ready_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Clock stretching
  // ---------------------------------------------------------------
  // Holding SCL while a command byte waits keeps the source of back-pressure at the bus.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_oe_q <= 1'b0;
    end else begin
      scl_oe_q <= en_w && st_q == DS_ACK && !rw_q && cmd_valid_o && !cmd_ready_i && !filt_q[0];
    end
  end

  // ---------------------------------------------------------------
  // Byte engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= DS_IDLE;
      rw_q <= 1'b0;
      cnt_q <= '0;
      sh_q <= '0;
      sda_oe_q <= 1'b0;
      idx_q <= '0;
      remain_q <= '0;
      cmd_valid_o <= 1'b0;
      cmd_data_o <= '0;
      cmd_last_o <= 1'b0;
      frame_err_o <= 1'b0;
    end else begin
      cmd_valid_o <= cmd_valid_o && !cmd_ready_i;
      frame_err_o <= 1'b0;
      if (!en_w || stop_w) begin
        st_q <= DS_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start_w) begin
        st_q <= DS_ADDR;
        cnt_q <= '0;
        sda_oe_q <= 1'b0;
      end else begin
        case (st_q)
          DS_ADDR, DS_WR: begin
            if (rise_w) begin
              sh_q <= {sh_q[6:0], filt_q[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall_w && cnt_q == TCSP_BIT_LAST) begin
              if (st_q == DS_WR) begin
                sda_oe_q <= 1'b1;
                st_q <= DS_ACK;
                idx_q <= (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;
                if (hdr_bad_w) begin
                  frame_err_o <= 1'b1;
                  remain_q <= '0;
                end else if (idx_q == 2'h2) begin
                  remain_q <= sh_q;
                end else if (idx_q == 2'h3 && remain_q != 8'h00) begin
                  cmd_data_o <= sh_q;
                  cmd_valid_o <= 1'b1;
                  cmd_last_o <= remain_q == 8'h01;
                  remain_q <= remain_q - 8'h01;
                end
              end else if (addr_hit_w) begin
                sda_oe_q <= 1'b1;
                rw_q <= sh_q[0];
                st_q <= DS_ACK;
                idx_q <= '0;
                remain_q <= '0;
              end else begin
                st_q <= DS_SKIP;
              end
            end
          end
          DS_ACK, DS_MACK: begin
            if (st_q == DS_MACK && rise_w && filt_q[1]) begin
              st_q <= DS_SKIP;
            end else if (fall_w && (st_q == DS_MACK || rw_q)) begin
              sh_q <= tx_byte_w;
              sda_oe_q <= !tx_byte_w[7];
              cnt_q <= 4'h1;
              st_q <= DS_RD;
            end else if (fall_w) begin
              sda_oe_q <= 1'b0;
              cnt_q <= '0;
              st_q <= DS_WR;
            end
          end
          DS_RD: begin
            if (fall_w && cnt_q == TCSP_BIT_LAST) begin
              sda_oe_q <= 1'b0;
              st_q <= DS_MACK;
            end else if (fall_w) begin
              sda_oe_q <= !sh_q[6];
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          DS_SKIP: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            st_q <= DS_IDLE;
          end
        endcase
      end
    end
  end

  // Outputs only ever pull low; the data-ready pin is driven both ways.
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe_q;
  assign bus.dev_scl_oe = scl_oe_q;
  assign bus.data_ready = ready_q;
endmodule // tcsp_device

// [tcsp_host.sv]
// Bus master end of the touch controller I2C port.
// Assumes bus pins come from outside the clock domain; user port is synchronous.
`timescale 1ns/100ps
module tcsp_host
  import tcsp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  tcsp_if.host bus,
  input wire logic req_valid_i,
  input wire logic req_read_i,
  input wire logic [7:0] req_len_i,
  output logic req_ready_o,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  output logic done_o,
  output logic nack_o,
  output logic data_ready_o
);
  localparam logic [4:0] QTR_LAST = 5'(TCSP_QTR_CYC - 1);
  localparam logic [9:0] WAIT_LAST = 10'(TCSP_STOP_WAIT_CYC - 1);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] filt_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= TCSP_HOST_SYNC_RST;
      s2_q <= TCSP_HOST_SYNC_RST;
      s3_q <= TCSP_HOST_SYNC_RST;
      filt_q <= TCSP_HOST_SYNC_RST;
    end else begin
      s1_q <= {bus.data_ready, bus.sda, bus.scl};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
    end
  end
  assign data_ready_o = filt_q[2];

  // ---------------------------------------------------------------
  // Quarter-bit divider
  // ---------------------------------------------------------------
  tcsp_host_state_type st_q;
  logic [4:0] div_q;
  logic tick_w;
  assign tick_w = div_q == QTR_LAST;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= '0;
    end else begin
      // A stretched high phase restarts the count so SCL high still lasts a full quarter.
      div_q <= (tick_w || (st_q == HS_HIGH && !filt_q[0])) ? 5'h00 : div_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic rd_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [2:0] idx_q;
  logic [8:0] remain_q;
  logic [7:0] len_q;
  logic [7:0] sh_q;
  logic [9:0] wait_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic tx_w;
  logic want_w;
  logic take_w;
  logic more_w;
  logic [7:0] pre_w;
  assign tx_w = idx_q == 3'h0 || !rd_q;
  assign want_w = st_q == HS_LOW && ph_q == 2'h0 && bit_q == 4'h0 && !rd_q && idx_q == 3'h4;
  assign take_w = want_w && wr_valid_i && wr_ready_o;
  assign more_w = (idx_q == 3'h0) ? remain_q != 9'h000 : remain_q != 9'h001;
  assign pre_w = (idx_q == 3'h1) ? TCSP_REG_CMD : (idx_q == 3'h2) ? TCSP_HDR : len_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ready_o <= 1'b0;
    end else begin
      wr_ready_o <= want_w && !take_w;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= HS_IDLE;
      rd_q <= 1'b0;
      ph_q <= '0;
      bit_q <= '0;
      idx_q <= '0;
      remain_q <= '0;
      len_q <= '0;
      sh_q <= '0;
      wait_q <= '0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      req_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      done_o <= 1'b0;
      nack_o <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      case (st_q)
        HS_IDLE: begin
          req_ready_o <= 1'b1;
          if (req_valid_i && req_ready_o) begin
            req_ready_o <= 1'b0;
            rd_q <= req_read_i;
            len_q <= req_len_i;
            remain_q <= req_read_i ? {1'b0, req_len_i} : {1'b0, req_len_i} + 9'h003;
            sh_q <= req_read_i ? TCSP_ADDR_RD : TCSP_ADDR_WR;
            idx_q <= '0;
            bit_q <= '0;
            nack_o <= 1'b0;
            st_q <= HS_START;
          end
        end
        HS_START: begin
          if (tick_w && !sda_oe_q) begin
            sda_oe_q <= 1'b1;
          end else if (tick_w) begin
            scl_oe_q <= 1'b1;
            ph_q <= '0;
            st_q <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (ph_q == 2'h0 && bit_q == 4'h0 && !rd_q && idx_q == 3'h4) begin
            if (take_w) begin
              sh_q <= wr_data_i;
              sda_oe_q <= !wr_data_i[7];
              ph_q <= 2'h1;
            end
          end else if (tick_w && ph_q == 2'h0) begin
            if (bit_q == TCSP_BIT_LAST) begin
              sda_oe_q <= !tx_w && more_w;
            end else if (bit_q == 4'h0 && !rd_q && idx_q != 3'h0) begin
              sh_q <= pre_w;
              sda_oe_q <= !pre_w[7];
            end else begin
              sda_oe_q <= tx_w && !sh_q[7];
            end
            ph_q <= 2'h1;
          end else if (tick_w) begin
            scl_oe_q <= 1'b0;
            ph_q <= 2'h2;
            st_q <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          // Two quarters high keep the bit rate below the 400 kHz ceiling.
          if (tick_w && filt_q[0] && ph_q == 2'h2) begin
            ph_q <= 2'h3;
          end else if (tick_w && filt_q[0]) begin
            scl_oe_q <= 1'b1;
            ph_q <= '0;
            st_q <= HS_LOW;
            if (bit_q != TCSP_BIT_LAST) begin
              sh_q <= {sh_q[6:0], filt_q[1]};
              bit_q <= bit_q + 4'h1;
            end else if (tx_w && filt_q[1]) begin
              nack_o <= 1'b1;
              st_q <= HS_STOP;
            end else begin
              if (!tx_w) begin
                rd_valid_o <= 1'b1;
                rd_data_o <= sh_q;
              end
              bit_q <= '0;
              idx_q <= (idx_q == 3'h4) ? idx_q : idx_q + 3'h1;
              remain_q <= (idx_q == 3'h0) ? remain_q : remain_q - 9'h001;
              if (!more_w) begin
                wait_q <= '0;
                st_q <= rd_q ? HS_STOP : HS_WAIT;
              end
            end
          end
        end
        HS_WAIT: begin
          // Covers controllers that cannot stretch the clock while they digest a command.
          wait_q <= wait_q + 10'h001;
          if (wait_q == WAIT_LAST) begin
            st_q <= HS_STOP;
          end
        end
        HS_STOP: begin
          if (tick_w && ph_q == 2'h0) begin
            sda_oe_q <= 1'b1;
            ph_q <= 2'h1;
          end else if (tick_w && ph_q == 2'h1) begin
            scl_oe_q <= 1'b0;
            ph_q <= 2'h2;
          end else if (tick_w && filt_q[0]) begin
            sda_oe_q <= 1'b0;
            done_o <= 1'b1;
            st_q <= HS_IDLE;
          end
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;
endmodule // tcsp_host

// [tcsp_chk.sv]
// Assertions on the wires between the two ends of the touch port.
// Assumes the signals of one tcsp_if instance and the device strap.
`timescale 1ns/100ps
module tcsp_chk
  import tcsp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic host_if_select_strap_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_o,
  input wire logic dev_sda_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic host_scl_o,
  input wire logic host_sda_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic data_ready
);
  logic scl_q, sda_q, first_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, addr_q;
  wire rise = scl && !scl_q;
  wire start = scl && sda_q && !sda;
  wire ninth = rise && cnt_q == 4'h8;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Bits are recounted from the wires so acks are judged without trusting the design's own state.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {scl_q, sda_q, first_q, cnt_q, sh_q, addr_q} <= {3'h6, 4'h0, 16'h0000};
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      cnt_q <= (start || ninth) ? 4'h0 : (rise ? cnt_q + 4'h1 : cnt_q);
      first_q <= start ? 1'b1 : (ninth ? 1'b0 : first_q);
      sh_q <= (rise && !ninth) ? {sh_q[6:0], sda} : sh_q;
      addr_q <= (ninth && first_q) ? sh_q : addr_q;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  open_drain_a: assert property (!dev_scl_o && !dev_sda_o && !host_scl_o && !host_sda_o)
    else $error("driver output not low");
  sda_stable_a: assert property (scl && scl_q && sda != sda_q |-> $changed(host_sda_oe))
    else $error("sda moved while scl high");
  dev_sda_low_a: assert property ($changed(dev_sda_oe) |-> !scl && !scl_q)
    else $error("device sda changed outside scl low");
  stretch_low_a: assert property ($rose(dev_scl_oe) |-> !scl_q)
    else $error("stretch began with scl high");
  host_wait_a: assert property ($rose(host_scl_oe) |-> scl_q)
    else $error("host clocked before scl released");
  stretch_end_a: assert property ($fell(host_scl_oe) |-> ##[0:1000] scl)
    else $error("scl held low too long");
  addr_byte_a: assert property (ninth && first_q |-> sh_q == TCSP_ADDR_WR || sh_q == TCSP_ADDR_RD)
    else $error("bad address byte");
  addr_ack_a: assert property (ninth && first_q && !host_if_select_strap_i |-> sda == (sh_q[7:1] != TCSP_ADDR))
    else $error("address ack wrong");
  wr_ack_a: assert property (ninth && !first_q && addr_q == TCSP_ADDR_WR && !host_if_select_strap_i |-> !sda)
    else $error("write byte not acked");
  ack_c: cover property (ninth && first_q && !sda);
  stretch_c: cover property ($rose(dev_scl_oe));
  ready_c: cover property ($fell(data_ready));
endmodule // tcsp_chk

// [tcsp_tb.sv]
// Testbench joining both ends of the touch port through one interface.
// Assumes the hand-over timing of both ends at a 20 MHz clock.
`timescale 1ns/100ps
module tcsp_tb
  import tcsp_pkg::*;
;
  logic clk_sys_i, rstn_i = 1'b0, strap = 1'b0, sleep = 1'b0, tx_valid = 1'b0, tx_first = 1'b0, tx_ready;
  logic cmd_valid, cmd_last, cmd_ready = 1'b0, req_valid = 1'b0, req_read = 1'b0, req_ready;
  logic wr_valid = 1'b0, wr_ready, rd_valid, done, nack, dr, ferr, ferr_seen = 1'b0;
  logic [7:0] tx_data = 8'h00, cmd_data, req_len = 8'h00, wr_data = 8'h00, rd_data;
  logic [7:0] rd_q[$];
  int num_errors = 0, n_checks = 0;
  tcsp_if bus_if();
  tcsp_device tcsp_device_inst(.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(bus_if), .host_if_select_strap_i(strap),
    .sleep_i(sleep), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_first_i(tx_first), .tx_ready_o(tx_ready),
    .cmd_valid_o(cmd_valid), .cmd_data_o(cmd_data), .cmd_last_o(cmd_last), .cmd_ready_i(cmd_ready),
    .frame_err_o(ferr));
  tcsp_host tcsp_host_inst(.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus(bus_if), .req_valid_i(req_valid),
    .req_read_i(req_read), .req_len_i(req_len), .req_ready_o(req_ready), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
    .wr_ready_o(wr_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .done_o(done), .nack_o(nack),
    .data_ready_o(dr));
  tcsp_chk tcsp_chk_inst(.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .host_if_select_strap_i(strap), .scl(bus_if.scl),
    .sda(bus_if.sda), .dev_scl_o(bus_if.dev_scl_o), .dev_sda_o(bus_if.dev_sda_o), .dev_scl_oe(bus_if.dev_scl_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .host_scl_o(bus_if.host_scl_o), .host_sda_o(bus_if.host_sda_o),
    .host_scl_oe(bus_if.host_scl_oe), .host_sda_oe(bus_if.host_sda_oe), .data_ready(bus_if.data_ready));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Sampled away from the rising edge so the one-cycle pulse is never raced.
  always @(negedge clk_sys_i) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (ferr === 1'b1) ferr_seen = 1'b1;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic host_run(input logic rd, input logic [7:0] len, input logic [7:0] b0, input logic [7:0] b1);
    rd_q.delete();
    req_read = rd;
    req_len = len;
    req_valid = 1'b1;
    repeat (100) if (req_ready !== 1'b1) tick();
    tick();
    req_valid = 1'b0;
    for (int i = 0; i < 2 && !rd; i++) begin
      wr_data = (i == 0) ? b0 : b1;
      wr_valid = 1'b1;
      repeat (5000) if (wr_ready !== 1'b1) tick();
      tick();
      wr_valid = 1'b0;
      tick();
    end
    repeat (20000) if (done !== 1'b1) tick();
    check("done", 8'(done), 8'h01);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("idle lines", {6'h00, bus_if.scl, bus_if.sda}, 8'h03);
    check("ready flag idle", 8'(bus_if.data_ready), 8'h00);
  endtask
  task automatic t_write();
    int n;
    fork
      host_run(1'b0, 8'h02, TCSP_CMD_TOUCH_EN, 8'hC3);
      begin
        for (int i = 0; i < 2; i++) begin
          repeat (5000) if (cmd_valid !== 1'b1) tick();
          tick(200);
          check("stretch", 8'(bus_if.scl), 8'h00);
          check("cmd byte", cmd_data, (i == 0) ? TCSP_CMD_TOUCH_EN : 8'hC3);
          check("cmd last", 8'(cmd_last), 8'(i));
          cmd_ready = 1'b1;
          tick();
          cmd_ready = 1'b0;
        end
        n = 0;
        while (done !== 1'b1 && n < 20000) begin
          tick();
          n++;
        end
        check("stop wait", 8'(n >= TCSP_STOP_WAIT_CYC), 8'h01);
      end
    join
    check("write nack", 8'(nack), 8'h00);
    check("frame error", 8'(ferr_seen), 8'h00);
  endtask
  task automatic t_fill();
    int i;
    i = 0;
    while (tx_ready === 1'b1 && i < 12) begin
      tx_valid = 1'b1;
      tx_data = 8'hA0 + 8'(i);
      tx_first = (i == 0);
      tick();
      i++;
    end
    tx_valid = 1'b0;
    tick(4);
    check("fifo depth", 8'(i), 8'(TCSP_FIFO_DEPTH));
    check("ready flag set", {6'h00, dr, bus_if.data_ready}, 8'h03);
    host_run(1'b1, 8'h09, 8'h00, 8'h00);
    for (i = 0; i < 9; i++) check("read byte", rd_q[i], (i < 8) ? 8'hA0 + 8'(i) : TCSP_FILLER);
    check("ready flag read", 8'(bus_if.data_ready), 8'h00);
  endtask
  task automatic t_sleep();
    tx_valid = 1'b1;
    tx_data = 8'h5A;
    tx_first = 1'b1;
    tick();
    tx_valid = 1'b0;
    sleep = 1'b1;
    tick(3);
    sleep = 1'b0;
    tick(4);
    check("ready flag sleep", 8'(bus_if.data_ready), 8'h00);
    host_run(1'b1, 8'h01, 8'h00, 8'h00);
    check("lost byte", rd_q[0], TCSP_FILLER);
  endtask
  task automatic t_strap();
    strap = 1'b1;
    tick(10);
    host_run(1'b1, 8'h01, 8'h00, 8'h00);
    check("strap nack", {nack, 7'(rd_q.size())}, 8'h80);
    strap = 1'b0;
    tick(10);
  endtask
  initial begin
    tick(2);
    rstn_i = 1'b1;
    tick(5);
    t_reset();
    t_write();
    t_fill();
    t_sleep();
    t_strap();
    stop_test();
  end
  initial begin
    #3_000_000;
    num_errors++;
    stop_test();
  end
endmodule // tcsp_tb
